// ==== ecsw_pkg.sv ====
// ecsw_pkg: constants and types for the encoder control/status word block
package ecsw_pkg;

	// =========================================================================
	// timing
	// =========================================================================
	localparam int CLK_PERIOD_NS = 5;        // 200 MHz
	localparam int NV_MIN_NS     = 5000000;  // nonvolatile store, least 5 ms
	localparam int NV_MAX_NS     = 10000000; // nonvolatile store, most 10 ms
	localparam int NV_MIN_CYC    = (NV_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int NV_MAX_CYC    = NV_MAX_NS / CLK_PERIOD_NS;
	localparam int NV_CNT_W      = 24;

	// =========================================================================
	// parameter record layout
	// =========================================================================
	localparam logic [15:0] REC_INDEX  = 16'hBF00;
	localparam int          REC_FLAGS  = 0;
	localparam int          REC_STEPS  = 1;
	localparam int          REC_TOTAL  = 9;
	localparam int          REC_FIELD  = 8;  // octets per resolution field
	localparam int          REC_SOL    = 17;
	localparam int          REC_VEL    = 18;
	localparam int          REC_LEN    = 19;
	localparam int          REC_ADDR_W = 5;

	// =========================================================================
	// reset values
	// =========================================================================
	localparam logic [7:0]  BYTE_RST = 8'h00;
	localparam logic [31:0] WORD_RST = 32'h0000_0000;
	localparam logic [15:0] STAT_RST = 16'h0000;

	// =========================================================================
	// control and status word layout, bit 15 down to bit 0
	// =========================================================================
	typedef struct packed {
		logic        ack;      // acknowledge sensor fault
		logic        park;     // sensor parking
		logic        abs_req;  // cyclic absolute value request
		logic        home_req; // set/shift home position, rising edge
		logic        home_rel; // 0 absolute set, 1 relative shift
		logic [10:0] rsvd;
	} ecsw_ctrl_t;

	typedef struct packed {
		logic        fault;    // sensor fault
		logic        park_ok;  // parking active
		logic        abs_ok;   // cyclic absolute value accepted
		logic        home_ok;  // home position set/shift carried out
		logic        ack_slow; // fault reset longer than one bus cycle
		logic [10:0] rsvd;
	} ecsw_stat_t;

	typedef struct packed {
		logic [7:0]  flags;
		logic [63:0] steps;
		logic [63:0] total;
		logic [7:0]  sol_limit;
		logic [7:0]  vel_unit;
	} ecsw_param_t;

	typedef enum logic [1:0] {
		S_IDLE  = 2'b00,
		S_STORE = 2'b01,
		S_DONE  = 2'b11
	} ecsw_home_t;

endpackage : ecsw_pkg

// ==== ecsw_core.sv ====
// ecsw_core: encoder control word interpreter and status word generator
`timescale 1ns/10ps

// =============================================================================
// Overview of operation
// - control bit 11: 0 loads preset as position, 1 adds preset as offset
// - rising edge on control bit 12 requests home set/shift; idle at 0
// - after home request, store offset; suppress position output 5 to 10 ms
// - control bit 13 set: send absolute position cyclically in second word
// - second word carries absolute position whenever nothing else needs it
// - while control bit 14 is set, suppress diagnostic and error reports
// - control bit 15 requests acknowledge and reset of a sensor fault
// - bits 0 to 10 of control and status words are reserved
// - status bit 11 set when fault reset takes over one bus cycle
// - status bit 12 confirms home set/shift carried out
// - status bit 13 confirms cyclic absolute value accepted
// - status bit 14 confirms parking active; no error reports then
// - status bit 15 flags sensor fault; second word carries error code
// - position goes out cyclically, preset comes in cyclically
// - startup parameter record at index 0xBF00 configures the device
// - record: steps per revolution octets 1..8, total resolution 9..16
// - record: sign-of-life fault limit octet 17, velocity unit octet 18
module ecsw_core #(
	parameter int NV_MIN = ecsw_pkg::NV_MIN_CYC,
	parameter int NV_MAX = ecsw_pkg::NV_MAX_CYC
) (
	input  wire logic                  clk,
	input  wire logic                  rst_b,
	input  wire logic                  bus_cycle,
	input  wire logic [15:0]           ctrl_word,
	input  wire logic [31:0]           preset_value,
	input  wire logic [31:0]           raw_position,
	input  wire logic                  fault_event,
	input  wire logic                  sensor_ok,
	input  wire logic [31:0]           fault_code,
	input  wire logic                  nv_busy,
	input  wire logic                  rec_wr,
	input  wire logic [15:0]           rec_index,
	input  wire logic [4:0]            rec_addr,
	input  wire logic [7:0]            rec_data,
	output logic                       nv_store,
	output logic [31:0]                nv_offset,
	output logic [15:0]                status_word,
	output logic [31:0]                position_word,
	output logic [31:0]                second_position_word,
	output logic                       position_valid,
	output ecsw_pkg::ecsw_param_t      param
);

	// local copies of package widths, used in size casts
	localparam int CW = ecsw_pkg::NV_CNT_W;
	localparam int AW = ecsw_pkg::REC_ADDR_W;

	// =========================================================================
	// control word decode
	// =========================================================================
	ecsw_pkg::ecsw_ctrl_t ctl;
	ecsw_pkg::ecsw_ctrl_t ctl_reg;
	ecsw_pkg::ecsw_ctrl_t ctl_next;
	logic                 home_edge;

	// only the named fields are kept; reserved bits never reach a flop
	assign ctl      = ctrl_word;
	assign ctl_next = '{ack: ctl.ack, park: ctl.park, abs_req: ctl.abs_req,
		home_req: ctl.home_req, home_rel: ctl.home_rel,
		rsvd: '0};
	assign home_edge = bus_cycle & ctl.home_req & ~ctl_reg.home_req;

	// last accepted control word, taken once per bus cycle
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			ctl_reg <= ecsw_pkg::ecsw_ctrl_t'(ecsw_pkg::STAT_RST);
		end else if (bus_cycle) begin
			ctl_reg <= ctl_next;
		end
	end

	// =========================================================================
	// home position sequence and nonvolatile store
	// =========================================================================
	ecsw_pkg::ecsw_home_t          state_reg;
	ecsw_pkg::ecsw_home_t          state_next;
	logic [ecsw_pkg::NV_CNT_W-1:0] cnt_reg;
	logic [ecsw_pkg::NV_CNT_W-1:0] cnt_next;
	logic [31:0]                   offset_reg;
	logic [31:0]                   offset_next;
	logic                          store_end;
	logic                          suppress;
	logic                          nv_store_reg;

	// absolute: position becomes preset; relative: preset adds on
	assign offset_next = ctl.home_rel ? offset_reg + preset_value
		: preset_value - raw_position;
	// store holds at least the least time, ends once nv_busy is low or at the longest time
	assign store_end = (cnt_reg >= CW'(NV_MIN - 1) && !nv_busy)
		|| cnt_reg >= CW'(NV_MAX - 1);
	assign suppress  = (state_reg == ecsw_pkg::S_STORE);
	assign cnt_next  = suppress ? cnt_reg + 1'b1 : '0;

	// next state of the home sequence
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			ecsw_pkg::S_IDLE: begin
				if (home_edge) begin
					state_next = ecsw_pkg::S_STORE;
				end
			end
			ecsw_pkg::S_STORE: begin
				if (store_end) begin
					state_next = ecsw_pkg::S_DONE;
				end
			end
			ecsw_pkg::S_DONE: begin
				if (bus_cycle && !ctl.home_req) begin
					state_next = ecsw_pkg::S_IDLE;
				end
			end
			default: begin
				state_next = ecsw_pkg::S_IDLE;
			end
		endcase
	end

	// state, store timer, offset and store strobe
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			state_reg    <= ecsw_pkg::S_IDLE;
			cnt_reg      <= '0;
			offset_reg   <= ecsw_pkg::WORD_RST;
			nv_store_reg <= 1'b0;
		end else begin
			state_reg    <= state_next;
			cnt_reg      <= cnt_next;
			nv_store_reg <= home_edge && state_reg == ecsw_pkg::S_IDLE;
			if (home_edge && state_reg == ecsw_pkg::S_IDLE) begin
				offset_reg <= offset_next;
			end
		end
	end

	assign nv_store  = nv_store_reg;
	assign nv_offset = offset_reg;

	// =========================================================================
	// sensor fault and acknowledge
	// =========================================================================
	logic fault_reg;
	logic ack_slow_reg;
	logic fault_clr;

	// acknowledge clears only a sensor that is healthy again; a new fault wins
	assign fault_clr = ctl_reg.ack & sensor_ok & ~fault_event;

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			fault_reg    <= 1'b0;
			ack_slow_reg <= 1'b0;
		end else begin
			fault_reg <= fault_event | (fault_reg & ~fault_clr);
			if (!fault_reg || !ctl_reg.ack) begin
				ack_slow_reg <= 1'b0;
			end else if (bus_cycle) begin
				ack_slow_reg <= 1'b1;
			end
		end
	end

	// =========================================================================
	// cyclic status and position words
	// =========================================================================
	ecsw_pkg::ecsw_stat_t stat_next;
	ecsw_pkg::ecsw_stat_t stat_reg;
	logic [31:0]          pos;
	logic                 report_fault;
	logic [31:0]          pos_reg;
	logic [31:0]          second_reg;
	logic                 valid_reg;

	assign pos          = raw_position + offset_reg;
	assign report_fault = fault_reg & ~ctl.park;
	assign stat_next = '{
		fault:    report_fault,
		park_ok:  ctl.park,
		abs_ok:   ctl.abs_req,
		home_ok:  state_reg == ecsw_pkg::S_DONE && ctl.home_req,
		ack_slow: ack_slow_reg & ~ctl.park,
		rsvd:     '0};

	// words refresh once per bus cycle; position held while storing
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			stat_reg   <= ecsw_pkg::ecsw_stat_t'(ecsw_pkg::STAT_RST);
			pos_reg    <= ecsw_pkg::WORD_RST;
			second_reg <= ecsw_pkg::WORD_RST;
			valid_reg  <= 1'b0;
		end else if (bus_cycle) begin
			stat_reg  <= stat_next;
			valid_reg <= ~suppress;
			if (!suppress) begin
				pos_reg    <= pos;
				second_reg <= report_fault ? fault_code : pos;
			end
		end
	end

	assign status_word          = stat_reg;
	assign position_word        = pos_reg;
	assign second_position_word = second_reg;
	assign position_valid       = valid_reg;

	// =========================================================================
	// startup parameter record
	// =========================================================================
	logic [7:0] rec_reg [ecsw_pkg::REC_LEN];
	logic       rec_hit;

	assign rec_hit = rec_wr && rec_index == ecsw_pkg::REC_INDEX
		&& rec_addr < AW'(ecsw_pkg::REC_LEN);

	// one octet per write; writes to other records are ignored
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			for (int i = 0; i < ecsw_pkg::REC_LEN; i++) begin
				rec_reg[i] <= ecsw_pkg::BYTE_RST;
			end
		end else if (rec_hit) begin
			rec_reg[rec_addr] <= rec_data;
		end
	end

	// resolution fields, most significant octet first
	for (genvar g = 0; g < ecsw_pkg::REC_FIELD; g++) begin : g_res
		assign param.steps[63-8*g -: 8] = rec_reg[ecsw_pkg::REC_STEPS+g];
		assign param.total[63-8*g -: 8] = rec_reg[ecsw_pkg::REC_TOTAL+g];
	end
	assign param.flags     = rec_reg[ecsw_pkg::REC_FLAGS];
	assign param.sol_limit = rec_reg[ecsw_pkg::REC_SOL];
	assign param.vel_unit  = rec_reg[ecsw_pkg::REC_VEL];

	// =========================================================================
	// assertions
	// =========================================================================
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);

	sequence s_home_start;
		home_edge && state_reg == ecsw_pkg::S_IDLE;
	endsequence

	sequence s_store_strobe;
		nv_store_reg && suppress ##1 !nv_store_reg;
	endsequence

	preset_abs_a: assert property ((s_home_start and !ctl.home_rel) |=>
		offset_reg == $past(preset_value) - $past(raw_position))
		else $error("absolute preset not loaded");

	preset_rel_a: assert property ((s_home_start and ctl.home_rel) |=>
		offset_reg == $past(offset_reg) + $past(preset_value))
		else $error("relative preset not added");

	home_store_a: assert property (s_home_start |=> s_store_strobe)
		else $error("home request did not start store");

	store_min_a: assert property (suppress && !$past(suppress) |->
		cnt_reg == '0) else $error("store timer not cleared");

	store_end_a: assert property (suppress && state_next !=
		ecsw_pkg::S_STORE |-> cnt_reg >= CW'(NV_MIN - 1)
		&& cnt_reg < CW'(NV_MAX))
		else $error("store left outside its window");

	hold_pos_a: assert property (bus_cycle && suppress |=>
		!position_valid && $stable(position_word))
		else $error("position sent while storing");

	abs_word_a: assert property (bus_cycle && !suppress
		&& !report_fault |=> second_position_word == $past(pos))
		else $error("second word not absolute position");

	err_code_a: assert property (bus_cycle && !suppress
		&& report_fault |=> second_position_word == $past(fault_code)
		&& status_word[15]) else $error("fault code missing");

	park_quiet_a: assert property (bus_cycle && ctl.park |=>
		status_word[14] && !status_word[15] && !status_word[11])
		else $error("error reported while parked");

	ack_clear_a: assert property (fault_reg && fault_clr |=>
		!fault_reg) else $error("fault not reset on acknowledge");

	rsvd_zero_a: assert property (status_word[10:0] == '0)
		else $error("reserved status bits not zero");

	ack_slow_a: assert property (bus_cycle && fault_reg && ctl_reg.ack
		&& !fault_clr |=> ack_slow_reg) else $error("slow reset not flagged");

	home_conf_a: assert property (bus_cycle && !ctl.home_req |=>
		!status_word[12]
		&& (state_reg != ecsw_pkg::S_DONE || $past(suppress)))
		else $error("home confirmation not cleared");

	abs_conf_a: assert property (bus_cycle |=>
		status_word[13] == $past(ctl.abs_req))
		else $error("absolute request not confirmed");

	rec_sol_a: assert property (rec_hit && rec_addr ==
		AW'(ecsw_pkg::REC_SOL) |=>
		param.sol_limit == $past(rec_data))
		else $error("sign-of-life limit not taken");

	park_conf_a: assert property (bus_cycle |=>
		status_word[14] == $past(ctl.park))
		else $error("parking not confirmed");

	home_ok_a: assert property (bus_cycle && ctl.home_req
		&& state_reg == ecsw_pkg::S_DONE |=> status_word[12])
		else $error("home confirmation missing");

	home_quiet_a: assert property (bus_cycle && suppress |=>
		!status_word[12]) else $error("home confirmed while storing");

	pos_word_a: assert property (bus_cycle && !suppress |=>
		position_word == $past(pos) && position_valid)
		else $error("position word not refreshed");

	fault_set_a: assert property (fault_event |=> fault_reg)
		else $error("sensor fault not latched");

	slow_clr_a: assert property (!fault_reg |=> !ack_slow_reg)
		else $error("slow flag left without a fault");

	rec_steps_a: assert property (rec_hit && rec_addr ==
		AW'(ecsw_pkg::REC_STEPS) |=>
		param.steps[63 -: 8] == $past(rec_data))
		else $error("steps octet not taken");

	rec_vel_a: assert property (rec_hit && rec_addr ==
		AW'(ecsw_pkg::REC_VEL) |=>
		param.vel_unit == $past(rec_data))
		else $error("velocity unit not taken");

	rec_foreign_a: assert property (rec_wr
		&& rec_index != ecsw_pkg::REC_INDEX |=> $stable(param))
		else $error("foreign record written");

endmodule : ecsw_core

// ==== ecsw_plc_model.sv ====
// ecsw_plc_model: behavioural network controller on the control side
`timescale 1ns/10ps

module ecsw_plc_model (
	input  wire logic        clk,
	output logic             bus_cycle,
	output logic [15:0]      ctrl_word,
	output logic [31:0]      preset_value,
	output logic             rec_wr,
	output logic [15:0]      rec_index,
	output logic [4:0]       rec_addr,
	output logic [7:0]       rec_data
);
	// =====================================================================
	// idle state
	// =====================================================================
	// home request rests low, no record write pending
	initial begin
		bus_cycle    = 1'b0;
		ctrl_word    = 16'h0000;
		preset_value = 32'h0000_0000;
		rec_wr       = 1'b0;
		rec_index    = 16'h0000;
		rec_addr     = 5'h00;
		rec_data     = 8'h00;
	end

	// =====================================================================
	// cyclic exchange
	// =====================================================================
	// n bus cycles, three clocks apart, word held until the next one
	task automatic bus(input logic [15:0] word, input logic [31:0] pre,
		input int n);
		for (int i = 0; i < n; i++) begin
			@(negedge clk);
			ctrl_word    = word;
			preset_value = pre;
			bus_cycle    = 1'b1;
			@(negedge clk);
			bus_cycle = 1'b0;
			@(negedge clk);
		end
	endtask : bus

	// =====================================================================
	// acyclic record
	// =====================================================================
	// one octet of the startup record; released index and data lose their value, address is held
	task automatic rec(input logic [15:0] idx, input logic [4:0] adr,
		input logic [7:0] dat);
		@(negedge clk);
		rec_wr    = 1'b1;
		rec_index = idx;
		rec_addr  = adr;
		rec_data  = dat;
		@(negedge clk);
		rec_wr    = 1'b0;
		rec_index = ~idx;
		rec_data  = ~dat;
	endtask : rec
endmodule : ecsw_plc_model

// ==== ecsw_tb.sv ====
// testbench: scenario bench for the encoder control/status word block
`timescale 1ns/10ps

module testbench;
	localparam int LIMIT = 20000; // clocks before a hang is cut short

	logic                  clk, rst_b, bus_cycle, fault_event, sensor_ok;
	logic                  nv_busy, rec_wr, nv_store, position_valid;
	logic [15:0]           ctrl_word, rec_index, status_word;
	logic [31:0]           preset_value, raw_position, fault_code;
	logic [31:0]           nv_offset, position_word, second_position_word;
	logic [4:0]            rec_addr;
	logic [7:0]            rec_data;
	ecsw_pkg::ecsw_param_t param;
	int                    bad_count, tests_run, cyc, stores;

	ecsw_core #(.NV_MIN(4), .NV_MAX(8)) dut (.clk(clk), .rst_b(rst_b),
		.bus_cycle(bus_cycle), .ctrl_word(ctrl_word),
		.preset_value(preset_value), .raw_position(raw_position),
		.fault_event(fault_event), .sensor_ok(sensor_ok),
		.fault_code(fault_code), .nv_busy(nv_busy), .rec_wr(rec_wr),
		.rec_index(rec_index), .rec_addr(rec_addr), .rec_data(rec_data),
		.nv_store(nv_store), .nv_offset(nv_offset),
		.status_word(status_word), .position_word(position_word),
		.second_position_word(second_position_word),
		.position_valid(position_valid), .param(param));

	ecsw_plc_model plc (.clk(clk), .bus_cycle(bus_cycle),
		.ctrl_word(ctrl_word), .preset_value(preset_value),
		.rec_wr(rec_wr), .rec_index(rec_index), .rec_addr(rec_addr),
		.rec_data(rec_data));

	// =====================================================================
	// reporting
	// =====================================================================
	task automatic check(input string what, input logic [159:0] got,
		input logic [159:0] exp);
		tests_run++;
		if (got !== exp) begin
			bad_count++;
			$display("ERROR %s expected %0h seen %0h", what, exp, got);
		end
	endtask : check

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : wrap_up

	// count store pulses and cut a hang short
	always @(posedge clk) begin
		cyc++;
		if (nv_store === 1'b1) stores++;
		if (cyc == LIMIT) begin
			bad_count++;
			$display("ERROR run time expected end seen hang");
			wrap_up();
		end
	end

	// =====================================================================
	// scenarios
	// =====================================================================
	task automatic t_record();
		plc.rec(16'hBF00, 5'h00, 8'h2D);
		for (int a = 1; a < 17; a++) begin
			plc.rec(16'hBF00, 5'(a), (a < 9) ? 8'(16 + a) : 8'(24 + a));
		end
		plc.rec(16'hBF00, 5'h11, 8'h5A);
		plc.rec(16'hBF00, 5'h12, 8'hA5);
		plc.rec(16'hBF01, 5'h11, 8'hFF); // foreign index
		plc.rec(16'hBF00, 5'h13, 8'hFF); // past the record end
		@(negedge clk);
		check("flags", param.flags, 8'h2D);
		check("steps", param.steps, 64'h1112_1314_1516_1718);
		check("total", param.total, 64'h2122_2324_2526_2728);
		check("sol limit", param.sol_limit, 8'h5A);
		check("vel unit", param.vel_unit, 8'hA5);
		$display("test record done");
	endtask : t_record

	task automatic t_home();
		raw_position = 32'h0000_0100;
		nv_busy = 1'b1;
		plc.bus(16'h0000, 32'h0000_0500, 1);
		plc.bus(16'h1000, 32'h0000_0500, 2);
		check("valid in store", position_valid, 1'b0);
		check("early ok", status_word[12], 1'b0);
		nv_busy = 1'b0;
		plc.bus(16'h1000, 32'h0000_0500, 4);
		check("offset", nv_offset, 32'h0000_0400);
		check("position", position_word, 32'h0000_0500);
		check("home ok", status_word[12], 1'b1);
		check("valid", position_valid, 1'b1);
		plc.bus(16'h07FF, 32'h0000_0010, 1);
		check("home clear", status_word[12], 1'b0);
		plc.bus(16'h1FFF, 32'h0000_0010, 6);
		check("shift", position_word, 32'h0000_0510);
		check("reserved", status_word[10:0], 11'h000);
		check("stores", stores, 2);
		plc.bus(16'h0000, 32'h0000_0000, 1);
		$display("test home done");
	endtask : t_home

	task automatic t_abs();
		raw_position = 32'h0000_0200;
		plc.bus(16'h2000, 32'h0000_0000, 2);
		check("abs ok", status_word[13], 1'b1);
		check("abs word", second_position_word, 32'h0000_0610);
		plc.bus(16'h0000, 32'h0000_0000, 1);
		check("abs clear", status_word[13], 1'b0);
		check("auto word", second_position_word, 32'h0000_0610);
		$display("test absolute done");
	endtask : t_abs

	task automatic t_fault();
		fault_code = 32'hE000_0042;
		@(negedge clk);
		fault_event = 1'b1;
		@(negedge clk);
		fault_event = 1'b0;
		plc.bus(16'h0000, 32'h0000_0000, 1);
		check("fault", status_word[15], 1'b1);
		check("code", second_position_word, 32'hE000_0042);
		plc.bus(16'h8000, 32'h0000_0000, 3);
		check("slow ack", status_word[15:11], 5'h11);
		plc.bus(16'hC000, 32'h0000_0000, 1);
		check("parked", status_word[15:11], 5'h08);
		check("park word", second_position_word, 32'h0000_0610);
		sensor_ok = 1'b1;
		plc.bus(16'h8000, 32'h0000_0000, 2);
		check("cleared", status_word[15:11], 5'h00);
		plc.bus(16'h0000, 32'h0000_0000, 1);
		check("pos word", second_position_word, 32'h0000_0610);
		$display("test fault done");
	endtask : t_fault

	// =====================================================================
	// clock and main sequence
	// =====================================================================
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	initial begin
		rst_b        = 1'b0;
		fault_event  = 1'b0;
		sensor_ok    = 1'b0;
		nv_busy      = 1'b0;
		raw_position = 32'h0000_0000;
		fault_code   = 32'h0000_0000;
		repeat (5) @(negedge clk);
		rst_b = 1'b1;
		check("reset status", status_word, 16'h0000);
		check("reset param", param, 152'h0);
		t_record();
		t_home();
		t_abs();
		t_fault();
		wrap_up();
	end
endmodule : testbench
